// ===== slb_top.sv
// Purpose: receive segment status, transmit ready and overflow, register slave
// Assumes: receive and transmit pipelines run on core_clk_i
// Notes:   interrupt status clears on read
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
`include "slb_cfg.svh"
module slb_top (
	input  wire logic               core_clk_i,
	input  wire logic               sys_rst_i,
	// receive pipeline side
	input  wire slb_pkg::slb_flag_type rxp_ena_i,
	input  wire slb_pkg::slb_flag_type rxp_sop_i,
	input  wire slb_pkg::slb_flag_type rxp_eop_i,
	input  wire slb_pkg::slb_flag_type rxp_err_i,
	input  wire slb_pkg::slb_mty_type  rxp_mty_i,
	input  wire slb_pkg::slb_data_type rxp_data_i,
	// receive segmented local bus to user logic
	output slb_pkg::slb_flag_type   rx_ena_o,
	output slb_pkg::slb_flag_type   rx_sop_o,
	output slb_pkg::slb_flag_type   rx_eop_o,
	output slb_pkg::slb_flag_type   rx_err_o,
	output slb_pkg::slb_mty_type    rx_mty_o,
	output slb_pkg::slb_data_type   rx_data_o,
	// transmit segmented local bus from user logic
	input  wire slb_pkg::slb_flag_type tx_ena_i,
	input  wire slb_pkg::slb_flag_type tx_sop_i,
	input  wire slb_pkg::slb_flag_type tx_eop_i,
	input  wire slb_pkg::slb_flag_type tx_err_i,
	input  wire slb_pkg::slb_mty_type  tx_mty_i,
	input  wire slb_pkg::slb_data_type tx_data_i,
	output logic                    tx_rdy_o,
	output logic                    tx_ovf_o,
	// transmit pipeline side
	input  wire logic               txp_drain_i,
	output logic                    txp_valid_o,
	output slb_pkg::slb_flag_type   txp_ena_o,
	output slb_pkg::slb_flag_type   txp_sop_o,
	output slb_pkg::slb_flag_type   txp_eop_o,
	output slb_pkg::slb_flag_type   txp_err_o,
	output slb_pkg::slb_mty_type    txp_mty_o,
	output slb_pkg::slb_data_type   txp_data_o,
	// AXI4-Lite slave
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	output logic [1:0]              s_axi_bresp,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	input  wire logic [7:0]         s_axi_araddr,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    irq_o
);
	import slb_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [2:0] count_set(input slb_flag_type f);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < `SLB_SEGS; i++) begin
			n = n + {2'h0, f[i]};
		end
		return n;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		logic k;
		k = (a == `SLB_OFF_CTRL) || (a == `SLB_OFF_TXCFG) || (a == `SLB_OFF_STATUS) ||
		    (a == `SLB_OFF_INTSTAT) || (a == `SLB_OFF_INTMASK) ||
		    (a == `SLB_OFF_RXPKT) || (a == `SLB_OFF_RXERR);
		return k;
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic                    rx_enable;
	logic                    tx_reset;
	logic [`SLB_FILL_W-1:0]  rdy_thresh;
	logic [`SLB_INT_W-1:0]   int_status;
	logic [`SLB_INT_W-1:0]   int_mask;
	logic [31:0]             rx_pkt_cnt;
	logic [31:0]             rx_err_cnt;
	logic [`SLB_FILL_W-1:0]  tx_fill;
	logic                    tx_ovf;
	logic                    tx_rdy;

	slb_bus_state_type       wr_state;
	logic                    aw_have;
	logic                    w_have;
	logic [7:0]              wr_addr;
	logic [31:0]             wr_data;
	logic [3:0]              wr_strb;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    int_read;

	slb_flag_type            rx_last;
	slb_flag_type            rx_bad;
	logic [`SLB_INT_W-1:0]   events;
	logic                    tx_take;
	logic                    tx_full;
	logic                    tx_pull;
	logic                    next_rdy;
	logic [`SLB_FILL_W-1:0]  next_fill;

	// ****************************************
	// receive segments
	// ****************************************
	for (genvar s = 0; s < `SLB_SEGS; s++) begin : g_seg
		slb_rx_seg u_seg (
			.core_clk_i (core_clk_i),
			.sys_rst_i  (sys_rst_i),
			.pass_i     (rx_enable),
			.ena_i      (rxp_ena_i[s]),
			.sop_i      (rxp_sop_i[s]),
			.eop_i      (rxp_eop_i[s]),
			.err_i      (rxp_err_i[s]),
			.mty_i      (rxp_mty_i[s]),
			.data_i     (rxp_data_i[s]),
			.ena_o      (rx_ena_o[s]),
			.sop_o      (rx_sop_o[s]),
			.eop_o      (rx_eop_o[s]),
			.err_o      (rx_err_o[s]),
			.mty_o      (rx_mty_o[s]),
			.data_o     (rx_data_o[s])
		);
	end

	assign rx_last = rxp_ena_i & rxp_eop_i & {`SLB_SEGS{rx_enable}};
	assign rx_bad  = rx_last & rxp_err_i;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_pkt_cnt <= 32'h0;
			rx_err_cnt <= 32'h0;
		end else begin
			rx_pkt_cnt <= rx_pkt_cnt + {29'h0, count_set(rx_last)};
			rx_err_cnt <= rx_err_cnt + {29'h0, count_set(rx_bad)};
		end
	end

	// ****************************************
	// transmit ready and overflow
	// ****************************************
	// fill models words held in the transmit path; drain empties it
	assign tx_full  = (tx_fill == `SLB_TX_DEPTH);
	assign tx_pull  = txp_drain_i && (tx_fill != 5'h0);
	assign tx_take  = (|tx_ena_i) && !tx_ovf && !tx_reset;

	always_comb begin
		next_fill = tx_fill;
		if (tx_take && !(tx_full && !tx_pull)) begin
			next_fill = next_fill + 5'h1;
		end
		if (tx_pull) begin
			next_fill = next_fill - 5'h1;
		end
	end

	// ready leaves headroom of depth minus threshold so late words still fit
	assign next_rdy = (next_fill < rdy_thresh) && !tx_ovf && !tx_reset;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_fill <= 5'h0;
			tx_rdy  <= 1'b0;
		end else if (tx_reset) begin
			tx_fill <= 5'h0;
			tx_rdy  <= 1'b0;
		end else begin
			tx_fill <= next_fill;
			tx_rdy  <= next_rdy;
		end
	end

	// overflow stays until software resets the transmit path
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_ovf <= 1'b0;
		end else if (tx_reset) begin
			tx_ovf <= 1'b0;
		end else if (tx_take && tx_full && !tx_pull) begin
			tx_ovf <= 1'b1;
		end
	end

	assign tx_rdy_o = tx_rdy;
	assign tx_ovf_o = tx_ovf;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			txp_valid_o <= 1'b0;
			txp_ena_o   <= '0;
			txp_sop_o   <= '0;
			txp_eop_o   <= '0;
			txp_err_o   <= '0;
			txp_mty_o   <= '0;
			txp_data_o  <= '0;
		end else begin
			txp_valid_o <= tx_take && !(tx_full && !tx_pull);
			txp_ena_o   <= tx_ena_i;
			txp_sop_o   <= tx_sop_i & tx_ena_i;
			txp_eop_o   <= tx_eop_i & tx_ena_i;
			txp_err_o   <= tx_err_i & tx_ena_i & tx_eop_i;
			txp_mty_o   <= tx_mty_i;
			txp_data_o  <= tx_data_i;
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign events[`SLB_INT_RXEOP_BIT]   = |rx_last;
	assign events[`SLB_INT_RXERR_BIT]   = |rx_bad;
	assign events[`SLB_INT_TXOVF_BIT]   = tx_take && tx_full && !tx_pull;
	assign events[`SLB_INT_RDYFALL_BIT] = tx_rdy && !next_rdy && !tx_reset;

	assign int_read = rd_fire && (s_axi_araddr == `SLB_OFF_INTSTAT);

	// a new event in the clearing read's cycle survives the clear
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			int_status <= '0;
		end else if (int_read) begin
			int_status <= events;
		end else begin
			int_status <= int_status | events;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(int_mask & (int_read ? events : (int_status | events)));
		end
	end

	// ****************************************
	// AXI4-Lite write
	// ****************************************
	assign wr_fire = aw_have && w_have && (wr_state == SLB_BUS_IDLE);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			wr_addr       <= 8'h0;
			wr_data       <= 32'h0;
			wr_strb       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have       <= 1'b1;
				wr_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_have && wr_state == SLB_BUS_IDLE) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have       <= 1'b1;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_have && wr_state == SLB_BUS_IDLE) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_have <= 1'b0;
				w_have  <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_state     <= SLB_BUS_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SLB_RESP_OKAY;
		end else begin
			unique case (wr_state)
				SLB_BUS_IDLE: begin
					if (wr_fire) begin
						wr_state     <= SLB_BUS_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= addr_known(wr_addr) ? `SLB_RESP_OKAY
						                                    : `SLB_RESP_SLVERR;
					end
				end
				SLB_BUS_RESP: begin
					if (s_axi_bready) begin
						wr_state     <= SLB_BUS_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// control: receive pass-through and one-cycle transmit path reset
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_enable  <= `SLB_CTRL_RST;
			tx_reset   <= 1'b0;
			rdy_thresh <= `SLB_TXCFG_RST;
			int_mask   <= '0;
		end else begin
			tx_reset <= 1'b0;
			if (wr_fire && wr_strb[0]) begin
				if (wr_addr == `SLB_OFF_CTRL) begin
					rx_enable <= wr_data[`SLB_CTRL_RXEN_BIT];
					tx_reset  <= wr_data[`SLB_CTRL_TXRST_BIT];
				end
				if (wr_addr == `SLB_OFF_TXCFG) begin
					rdy_thresh <= wr_data[`SLB_FILL_W-1:0];
				end
				if (wr_addr == `SLB_OFF_INTMASK) begin
					int_mask <= wr_data[`SLB_INT_W-1:0];
				end
			end
		end
	end

	// ****************************************
	// AXI4-Lite read
	// ****************************************
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `SLB_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= addr_known(s_axi_araddr) ? `SLB_RESP_OKAY
			                                           : `SLB_RESP_SLVERR;
			unique case (s_axi_araddr)
				`SLB_OFF_CTRL:    s_axi_rdata <= {31'h0, rx_enable};
				`SLB_OFF_TXCFG:   s_axi_rdata <= {27'h0, rdy_thresh};
				`SLB_OFF_STATUS:  s_axi_rdata <= {25'h0, tx_rdy, tx_ovf, tx_fill};
				`SLB_OFF_INTSTAT: s_axi_rdata <= {28'h0, int_status};
				`SLB_OFF_INTMASK: s_axi_rdata <= {28'h0, int_mask};
				`SLB_OFF_RXPKT:   s_axi_rdata <= rx_pkt_cnt;
				`SLB_OFF_RXERR:   s_axi_rdata <= rx_err_cnt;
				default:          s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule // slb_top
`default_nettype wire

// ===== slb_cfg.svh
// Purpose: constants of the segmented local bus receive status and transmit ready block
// Assumes: one clock, AXI4-Lite register access with 32-bit data
// Notes:   offsets are byte addresses
// Function
// - receive bus has four segments, each with enable, end, error and empty count
// - end-of-packet flag high on a packet's last transfer, only with enable
// - error flag high marks an errored packet, valid only with enable and end
// - with enable and end high, error low means packet ended cleanly
// - four-bit empty count gives invalid bytes of the last transfer
// - error and enable high force low three empty bits to zero; txp_mty_o copies tx_mty_i unchanged
// - transmit ready high while the transmit path can accept data
// - each segment carries a 128-bit word, valid only with enable
// - start-of-packet flag high on a packet's first transfer, only with enable
// - ignored back-pressure raises overflow; transmit path then needs a reset
`ifndef SLB_CFG_SVH
`define SLB_CFG_SVH

`define SLB_SEGS        4
`define SLB_DATA_W      128
`define SLB_MTY_W       4
`define SLB_TX_DEPTH    5'h10
`define SLB_FILL_W      5

// ****************************************
// register offsets
// ****************************************
`define SLB_OFF_CTRL    8'h00
`define SLB_OFF_TXCFG   8'h04
`define SLB_OFF_STATUS  8'h08
`define SLB_OFF_INTSTAT 8'h0C
`define SLB_OFF_INTMASK 8'h10
`define SLB_OFF_RXPKT   8'h14
`define SLB_OFF_RXERR   8'h18

// ****************************************
// fields and reset values
// ****************************************
`define SLB_CTRL_RXEN_BIT    0
`define SLB_CTRL_TXRST_BIT   1
`define SLB_CTRL_RST         1'h1
`define SLB_TXCFG_RST        5'h0C
`define SLB_INT_RXEOP_BIT    0
`define SLB_INT_RXERR_BIT    1
`define SLB_INT_TXOVF_BIT    2
`define SLB_INT_RDYFALL_BIT  3
`define SLB_INT_W            4
`define SLB_STAT_OVF_BIT     5
`define SLB_STAT_RDY_BIT     6
`define SLB_RESP_OKAY        2'h0
`define SLB_RESP_SLVERR      2'h2

`endif

// ===== slb_pkg.sv
// Purpose: types of the segmented local bus block
// Assumes: slb_cfg.svh holds the numbers
// Notes:   none
`default_nettype none
`include "slb_cfg.svh"
package slb_pkg;
	typedef logic [`SLB_SEGS-1:0][`SLB_DATA_W-1:0] slb_data_type;
	typedef logic [`SLB_SEGS-1:0][`SLB_MTY_W-1:0]  slb_mty_type;
	typedef logic [`SLB_SEGS-1:0]                  slb_flag_type;
	typedef enum logic [0:0] {
		SLB_BUS_IDLE = 1'b0,
		SLB_BUS_RESP = 1'b1
	} slb_bus_state_type;
endpackage
`default_nettype wire

// ===== slb_rx_seg.sv
// Purpose: one receive segment output stage
// Assumes: inputs come from the receive pipeline on the same clock
// Notes:   every output is a flip-flop
`default_nettype none
`include "slb_cfg.svh"
module slb_rx_seg (
	input  wire logic                   core_clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   pass_i,
	input  wire logic                   ena_i,
	input  wire logic                   sop_i,
	input  wire logic                   eop_i,
	input  wire logic                   err_i,
	input  wire logic [`SLB_MTY_W-1:0]  mty_i,
	input  wire logic [`SLB_DATA_W-1:0] data_i,
	output logic                        ena_o,
	output logic                        sop_o,
	output logic                        eop_o,
	output logic                        err_o,
	output logic      [`SLB_MTY_W-1:0]  mty_o,
	output logic      [`SLB_DATA_W-1:0] data_o
);
	logic en;
	logic last;
	logic bad;

	assign en   = ena_i & pass_i;
	assign last = en & eop_i;
	assign bad  = last & err_i;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ena_o <= 1'b0;
			sop_o <= 1'b0;
			eop_o <= 1'b0;
			err_o <= 1'b0;
			mty_o <= 4'h0;
		end else begin
			ena_o <= en;
			sop_o <= en & sop_i;
			eop_o <= last;
			err_o <= bad;
			mty_o <= last ? {mty_i[3], bad ? 3'h0 : mty_i[2:0]} : 4'h0;
		end
	end

	// data holds its last word between enabled cycles to save toggling
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			data_o <= '0;
		end else if (en) begin
			data_o <= data_i;
		end
	end
endmodule // slb_rx_seg
`default_nettype wire

// ===== slb_top_sva.sv
// Purpose: port-level assertions for slb_top
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound from the bench top file
`default_nettype none
module slb_top_sva (
	input wire logic                  core_clk_i,
	input wire logic                  sys_rst_i,
	input wire slb_pkg::slb_flag_type rxp_ena_i,
	input wire slb_pkg::slb_flag_type rxp_sop_i,
	input wire slb_pkg::slb_flag_type rxp_eop_i,
	input wire slb_pkg::slb_flag_type rxp_err_i,
	input wire slb_pkg::slb_mty_type  rxp_mty_i,
	input wire slb_pkg::slb_data_type rxp_data_i,
	input wire slb_pkg::slb_flag_type rx_ena_o,
	input wire slb_pkg::slb_flag_type rx_sop_o,
	input wire slb_pkg::slb_flag_type rx_eop_o,
	input wire slb_pkg::slb_flag_type rx_err_o,
	input wire slb_pkg::slb_mty_type  rx_mty_o,
	input wire slb_pkg::slb_data_type rx_data_o,
	input wire slb_pkg::slb_flag_type tx_ena_i,
	input wire slb_pkg::slb_flag_type tx_sop_i,
	input wire slb_pkg::slb_flag_type tx_eop_i,
	input wire slb_pkg::slb_flag_type tx_err_i,
	input wire slb_pkg::slb_mty_type  tx_mty_i,
	input wire slb_pkg::slb_data_type tx_data_i,
	input wire logic                  tx_rdy_o,
	input wire logic                  tx_ovf_o,
	input wire logic                  txp_valid_o,
	input wire slb_pkg::slb_flag_type txp_ena_o,
	input wire slb_pkg::slb_flag_type txp_sop_o,
	input wire slb_pkg::slb_flag_type txp_eop_o,
	input wire slb_pkg::slb_flag_type txp_err_o,
	input wire slb_pkg::slb_mty_type  txp_mty_o,
	input wire slb_pkg::slb_data_type txp_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import slb_pkg::*;
	logic [3:0] mty_bad;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ****************************************
	// receive segments
	// ****************************************
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			mty_bad[k] = rx_err_o[k] & rx_ena_o[k] & (rx_mty_o[k][2:0] != 3'h0);
		end
	end
	property p_ena; (rx_ena_o & ~$past(rxp_ena_i)) == 4'h0; endproperty
	a_ena: assert property (p_ena) else $error("enable without input");
	property p_eop; rx_eop_o == ($past(rxp_eop_i) & rx_ena_o); endproperty
	a_eop: assert property (p_eop) else $error("end flag wrong");
	property p_sop; rx_sop_o == ($past(rxp_sop_i) & rx_ena_o); endproperty
	a_sop: assert property (p_sop) else $error("start flag wrong");
	property p_err; rx_err_o == ($past(rxp_err_i) & rx_eop_o); endproperty
	a_err: assert property (p_err) else $error("error flag wrong");
	property p_mty0; mty_bad == 4'h0; endproperty
	a_mty0: assert property (p_mty0) else $error("empty low bits not cleared");
	for (genvar k = 0; k < 4; k++) begin : g_seg
		property p_mty;
			rx_ena_o[k] && rx_eop_o[k] && !rx_err_o[k] |-> rx_mty_o[k] == $past(rxp_mty_i[k]);
		endproperty
		a_mty: assert property (p_mty) else $error("empty count wrong");
		property p_data; rx_ena_o[k] |-> rx_data_o[k] == $past(rxp_data_i[k]); endproperty
		a_data: assert property (p_data) else $error("data word wrong");
	end
	// ****************************************
	// transmit ready and overflow
	// ****************************************
	property p_take; (tx_ena_i != 4'h0) && tx_rdy_o |=> txp_valid_o; endproperty
	a_take: assert property (p_take) else $error("word lost while ready");
	property p_ovfrdy; tx_ovf_o |-> !tx_rdy_o; endproperty
	a_ovfrdy: assert property (p_ovfrdy) else $error("ready during overflow");
	property p_ovfwhy;
		$rose(tx_ovf_o) |-> ($past(tx_ena_i) != 4'h0) && !$past(tx_rdy_o);
	endproperty
	a_ovfwhy: assert property (p_ovfwhy) else $error("overflow without cause");
	property p_drop; tx_ovf_o && (tx_ena_i != 4'h0) |=> !txp_valid_o; endproperty
	a_drop: assert property (p_drop) else $error("word passed in overflow");
	// an accepted word leaves a cycle later with flags qualified by enable
	property p_pass;
		txp_valid_o |-> (txp_ena_o == $past(tx_ena_i)) &&
			(txp_sop_o == ($past(tx_sop_i) & $past(tx_ena_i))) &&
			(txp_eop_o == ($past(tx_eop_i) & $past(tx_ena_i))) &&
			(txp_err_o == ($past(tx_err_i) & $past(tx_ena_i) & $past(tx_eop_i))) &&
			(txp_mty_o == $past(tx_mty_i)) && (txp_data_o == $past(tx_data_i));
	endproperty
	a_pass: assert property (p_pass) else $error("transmit word not passed");
endmodule // slb_top_sva
`default_nettype wire

// ===== slb_user_model.sv
// Purpose: user packet logic feeding the transmit bus
// Assumes: reacts to ready one cycle late
// Notes:   payload moves every cycle, only enable qualifies it
`default_nettype none
module slb_user_model (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             run_i,
	input  wire logic             rdy_i,
	input  wire logic             ignore_i,
	output slb_pkg::slb_flag_type ena_o,
	output slb_pkg::slb_flag_type sop_o,
	output slb_pkg::slb_flag_type eop_o,
	output slb_pkg::slb_flag_type err_o,
	output slb_pkg::slb_mty_type  mty_o,
	output slb_pkg::slb_data_type data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import slb_pkg::*;
	logic [7:0] cnt;
	// ****************************************
	// sending
	// ****************************************
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt   <= 8'h00;
			ena_o <= 4'h0;
		end else begin
			cnt   <= cnt + 8'h01;
			// ignore_i breaks back-pressure on purpose
			ena_o <= (run_i && (rdy_i || ignore_i)) ? 4'hF : 4'h0;
		end
	end
	// idle payload keeps changing so no stale value can pass
	assign sop_o  = cnt[3:0];
	assign eop_o  = ~cnt[3:0];
	assign err_o  = cnt[7:4];
	assign mty_o  = {4{cnt[7:4]}};
	assign data_o = {64{cnt}};
endmodule // slb_user_model
`default_nettype wire

// ===== tb_slb_top.sv
// Purpose: self-checking bench for slb_top
// Assumes: 10 MHz clock, reset held 20 cycles
// Notes:   transmit traffic comes from slb_user_model
`default_nettype none
module tb_slb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import slb_pkg::*;
	logic         core_clk_i = 1'b0;
	logic         sys_rst_i  = 1'b1;
	slb_flag_type rxp_ena_i, rxp_sop_i, rxp_eop_i, rxp_err_i, rx_ena_o, rx_sop_o, rx_eop_o;
	slb_flag_type rx_err_o, tx_ena_i, tx_sop_i, tx_eop_i, tx_err_i;
	slb_flag_type txp_ena_o, txp_sop_o, txp_eop_o, txp_err_o;
	slb_mty_type  rxp_mty_i, rx_mty_o, tx_mty_i, txp_mty_o;
	slb_data_type rxp_data_i, rx_data_o, tx_data_i, txp_data_o;
	logic         tx_rdy_o, tx_ovf_o, txp_drain_i, txp_valid_o, irq_o, run, ign;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, d;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, r;
	int           bad_count = 0;
	int           n_tests   = 0;
	int           i;

	always #50 core_clk_i = ~core_clk_i;

	slb_top dut_u (.*);
	slb_user_model usr_u (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.run_i      (run),
		.rdy_i      (tx_rdy_o),
		.ignore_i   (ign),
		.ena_o      (tx_ena_i),
		.sop_o      (tx_sop_i),
		.eop_o      (tx_eop_i),
		.err_o      (tx_err_i),
		.mty_o      (tx_mty_i),
		.data_o     (tx_data_i)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tmo();
		if (i >= 100) begin
			bad_count++;
			$display("ERROR %0t: wait ran out", $time);
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_wstrb   <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge core_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		tmo();
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge core_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		tmo();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rxv(input slb_flag_type e, s, p, x, input slb_mty_type m,
			input slb_data_type v);
		rxp_ena_i  <= e;
		rxp_sop_i  <= s;
		rxp_eop_i  <= p;
		rxp_err_i  <= x;
		rxp_mty_i  <= m;
		rxp_data_i <= v;
		@(posedge core_clk_i);
		#1;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rxp_ena_i, rxp_sop_i, rxp_eop_i, rxp_err_i, rxp_mty_i, rxp_data_i} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{txp_drain_i, run, ign} = '0;
		repeat (20) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h04);
		chk(d, 32'h0C);
		rd(8'h08);
		chk(d, 32'h40);
		rd(8'hFC);
		chk({r, d}, 34'h200000000);
		wr(8'h10, 32'h3);
		@(posedge core_clk_i);
		#1;
		// back-to-back transfers, errored ends in segments 1 and 2, then in 0 and 2
		rxv(4'hF, 4'h3, 4'hE, 4'h6, 16'hFD75, {16{32'h5A3C_96E1}});
		chk({rx_ena_o, rx_sop_o, rx_eop_o, rx_err_o}, 16'hF3E6);
		chk(rx_mty_o, 16'hF800);
		chk(rx_data_o[1], {4{32'h5A3C_96E1}});
		rxv(4'h5, 4'hF, 4'hF, 4'hF, 16'h9999, {16{32'hA5C3_691E}});
		chk({rx_ena_o, rx_sop_o, rx_eop_o, rx_err_o}, 16'h5555);
		chk(rx_mty_o, 16'h0808);
		chk(rx_data_o[2], {4{32'hA5C3_691E}});
		rxv('0, '0, '0, '0, '0, '0);
		repeat (3) @(posedge core_clk_i);
		chk(irq_o, 1'b1);
		rd(8'h0C);
		chk(d, 32'h3);
		rd(8'h0C);
		chk(d, 32'h0);
		rd(8'h14);
		chk(d, 32'h5);
		rd(8'h18);
		chk(d, 32'h4);
		wr(8'h00, 32'h0);
		rxv(4'hF, 4'h0, 4'hF, 4'h0, '0, '0);
		chk(rx_ena_o, 4'h0);
		rxv('0, '0, '0, '0, '0, '0);
		chk(irq_o, 1'b0);
		wr(8'h00, 32'h1);
		// transmit: user stops one cycle after ready falls, no drain
		run <= 1'b1;
		repeat (30) @(posedge core_clk_i);
		rd(8'h08);
		chk(d, 32'h0D);
		txp_drain_i <= 1'b1;
		for (i = 0; i < 100 && tx_rdy_o !== 1'b1; i++) @(posedge core_clk_i);
		tmo();
		txp_drain_i <= 1'b0;
		ign <= 1'b1;
		for (i = 0; i < 100 && tx_ovf_o !== 1'b1; i++) @(posedge core_clk_i);
		tmo();
		ign <= 1'b0;
		rd(8'h08);
		chk(d, 32'h30);
		rd(8'h0C);
		chk(d, 32'hC);
		run <= 1'b0;
		wr(8'h00, 32'h3);
		for (i = 0; i < 100 && tx_rdy_o !== 1'b1; i++) @(posedge core_clk_i);
		tmo();
		chk(tx_ovf_o, 1'b0);
		rd(8'h08);
		chk(d, 32'h40);
		wr(8'h04, 32'h8);
		rd(8'h04);
		chk(d, 32'h8);
		wr(8'hFC, 32'h0);
		chk(r, 2'h2);
		tally_and_finish();
	end
endmodule // tb_slb_top
bind slb_top slb_top_sva chk_u (.*);
`default_nettype wire
